// ---- sap_codec_model.sv ----
// far-side codec model on the shared pins
module sap_codec_model (
   input wire sap_pkg::sap_pad_s i_pad,
   input wire logic [3:0] i_drive,
   output logic [3:0] o_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   assign o_pin = (i_pad.oe & i_pad.out) | (~i_pad.oe & i_drive);
endmodule

// ---- sap_pin_share.sv ----
// pin sharing for the four shared serial audio data pins
// Behaviour
// - primary lines 3,2 as transmitters drive pins from tx shift regs 3,2
// - pins 1,0 always carry tx shift regs 1,0 when primary owns them
// - primary lines 2,3 as receivers capture pins into rx shift regs 2,3
// - second port enabled routes pins to its outputs 0-3, inputs 2,3
// - primary gpio mode: each pin input, output or disconnected
// - second port gpio presents pins as second gpio bits 8 to 11
// - after reset every pin is gpio and disconnected
module sap_pin_share (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_primary_en,
   input wire logic i_primary_gpio,
   input wire logic [3:0] i_primary_rx_sel,
   input wire sap_pkg::sap_port_out_s i_primary,
   input wire logic i_second_en,
   input wire logic i_second_gpio,
   input wire sap_pkg::sap_port_out_s i_second,
   input wire logic [3:0] i_gpio_en,
   input wire logic [3:0] i_gpio_dir,
   input wire logic [3:0] i_gpio_out,
   input wire logic [3:0] i_pin_in,
   output sap_pkg::sap_pad_s o_pad,
   output logic [3:0] o_primary_rx,
   output logic [3:0] o_second_rx,
   output logic [3:0] o_first_gpio_in,
   output logic [3:0] o_second_gpio_in,
   output sap_pkg::sap_owner_e o_owner
);
   logic [3:0] pin_meta_ff;
   logic [3:0] pin_sync_ff;
   sap_pkg::sap_owner_e owner_ff;
   sap_pkg::sap_owner_e nxt_owner;
   logic gpio_second_ff;
   logic [3:0] gpio_en_ff;
   logic [3:0] gpio_dir_ff;
   logic [3:0] gpio_out_ff;
   logic [3:0] rx_sel_ff;
   sap_pkg::sap_pad_s nxt_pad;
   sap_pkg::sap_pad_s pad_ff;

   // pin synchroniser
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         pin_meta_ff <= 4'h0;
         pin_sync_ff <= 4'h0;
      end else if (i_ce) begin
         pin_meta_ff <= i_pin_in;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   always_comb begin
      if (i_second_en && !i_second_gpio) begin
         nxt_owner = sap_pkg::SAP_OWN_SECOND;
      end else if (i_primary_en && !i_primary_gpio && !i_second_en) begin
         nxt_owner = sap_pkg::SAP_OWN_PRIMARY;
      end else begin
         nxt_owner = sap_pkg::SAP_OWN_GPIO;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         owner_ff <= sap_pkg::SAP_OWN_GPIO;
         gpio_second_ff <= 1'b0;
      end else if (i_ce) begin
         owner_ff <= nxt_owner;
         gpio_second_ff <= i_second_en && i_second_gpio;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         gpio_en_ff <= sap_pkg::RESET_GPIO_EN;
         gpio_dir_ff <= sap_pkg::RESET_GPIO_DIR;
         gpio_out_ff <= 4'h0;
         rx_sel_ff <= sap_pkg::RESET_RX_SEL;
      end else if (i_ce) begin
         gpio_en_ff <= i_gpio_en;
         gpio_dir_ff <= i_gpio_dir;
         gpio_out_ff <= i_gpio_out;
         rx_sel_ff <= i_primary_rx_sel;
      end
   end

   // pad drive per owner
   always_comb begin
      nxt_pad.out = 4'h0;
      nxt_pad.oe = 4'h0;
      case (owner_ff)
         sap_pkg::SAP_OWN_PRIMARY: begin
            nxt_pad.out = i_primary.tx_data;
            nxt_pad.oe[1:0] = 2'h3;
            nxt_pad.oe[3:2] = i_primary.tx_en[3:2] & ~rx_sel_ff[3:2];
         end
         sap_pkg::SAP_OWN_SECOND: begin
            nxt_pad.out = i_second.tx_data;
            nxt_pad.oe = {i_second.tx_en[3:2], 2'h3};
         end
         sap_pkg::SAP_OWN_GPIO: begin
            nxt_pad.out = gpio_out_ff;
            nxt_pad.oe = gpio_en_ff & gpio_dir_ff;
         end
         default: begin
            nxt_pad.out = 4'h0;
            nxt_pad.oe = 4'h0;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         pad_ff <= '0;
      end else if (i_ce) begin
         pad_ff <= nxt_pad;
      end
   end

   // input routing
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_primary_rx <= 4'h0;
         o_second_rx <= 4'h0;
         o_first_gpio_in <= 4'h0;
         o_second_gpio_in <= 4'h0;
      end else if (i_ce) begin
         o_primary_rx <= (owner_ff == sap_pkg::SAP_OWN_PRIMARY) ?
            {pin_sync_ff[3:2] & rx_sel_ff[3:2], 2'h0} : 4'h0;
         o_second_rx <= (owner_ff == sap_pkg::SAP_OWN_SECOND) ?
            {pin_sync_ff[3:2], 2'h0} : 4'h0;
         if (owner_ff == sap_pkg::SAP_OWN_GPIO) begin
            o_first_gpio_in <= gpio_second_ff ? 4'h0 :
               (pin_sync_ff & gpio_en_ff & ~gpio_dir_ff);
            o_second_gpio_in <= gpio_second_ff ?
               (pin_sync_ff & gpio_en_ff & ~gpio_dir_ff) : 4'h0;
         end else begin
            o_first_gpio_in <= 4'h0;
            o_second_gpio_in <= 4'h0;
         end
      end
   end

   assign o_pad = pad_ff;
   assign o_owner = owner_ff;
endmodule

// ---- sap_pin_share_checker.sv ----
// assertions on the shared serial audio data pins
module sap_pin_share_checker (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_second_en,
   input wire logic i_second_gpio,
   input wire logic [3:0] i_gpio_en,
   input wire logic [3:0] i_gpio_dir,
   input wire logic [3:0] i_pin_in,
   input wire sap_pkg::sap_pad_s o_pad,
   input wire logic [3:0] o_second_rx,
   input wire logic [3:0] o_first_gpio_in,
   input wire logic [3:0] o_second_gpio_in,
   input wire sap_pkg::sap_owner_e o_owner
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset || !i_ce);
   chk_owner_onehot: assert property ($onehot(o_owner)) else $error("owner");
   chk_reset_idle: assert property ($past(i_reset) |-> o_pad.oe == 4'h0 &&
      o_owner == sap_pkg::SAP_OWN_GPIO) else $error("idle");
   chk_second_owns: assert property (i_second_en && !i_second_gpio |=>
      o_owner == sap_pkg::SAP_OWN_SECOND) else $error("second owner");
   chk_primary_pads: assert property (o_owner == sap_pkg::SAP_OWN_PRIMARY [*2] |->
      o_pad.oe[1:0] == 2'h3) else $error("primary pads");
   chk_gpio_oe: assert property (o_owner == sap_pkg::SAP_OWN_GPIO [*2] |->
      (o_pad.oe & ~$past(i_gpio_en & i_gpio_dir, 2)) == 4'h0) else $error("gpio oe");
   chk_gpio_dis: assert property ((o_owner == sap_pkg::SAP_OWN_GPIO && $stable(i_gpio_en) &&
      $stable(i_gpio_dir))[*4] |-> ((o_first_gpio_in | o_second_gpio_in) &
      ~(i_gpio_en & ~i_gpio_dir)) == 4'h0) else $error("gpio read");
   chk_second_gpio: assert property ((i_second_en && i_second_gpio && i_gpio_en == 4'hF &&
      i_gpio_dir == 4'h0 && $stable(i_pin_in))[*4] |-> o_second_gpio_in == i_pin_in &&
      o_first_gpio_in == 4'h0) else $error("second gpio");
   chk_second_rx: assert property ((o_owner == sap_pkg::SAP_OWN_SECOND &&
      $stable(i_pin_in))[*4] |-> o_second_rx[3:2] == i_pin_in[3:2]) else $error("second rx");
endmodule
bind sap_pin_share sap_pin_share_checker chk (.*);

// ---- sap_pkg.sv ----
// package for the serial audio pin sharing block
package sap_pkg;
   localparam int NUM_PINS = 4;
   localparam int GPIO2_LSB = 8;
   localparam int GPIO2_MSB = 11;
   localparam int FIRST_GPIO_LSB = 8;
   localparam logic [3:0] RESET_GPIO_DIR = 4'h0;
   localparam logic [3:0] RESET_GPIO_EN = 4'h0;
   localparam logic [3:0] RESET_RX_SEL = 4'h0;

   // pin ownership, one-hot
   typedef enum logic [2:0] {
      SAP_OWN_GPIO = 3'h1,
      SAP_OWN_PRIMARY = 3'h2,
      SAP_OWN_SECOND = 3'h4
   } sap_owner_e;

   // one audio port facing the pins
   typedef struct packed {
      logic [3:0] tx_data;
      logic [3:0] tx_en;
   } sap_port_out_s;

   // pad drive toward the pins
   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
   } sap_pad_s;
endpackage

// ---- tb_sap_pin_share.sv ----
// testbench for the shared serial audio data pins
module tb_sap_pin_share;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 0, i_reset = 1, pe = 0, pg = 0, se = 0, sg = 0, ce = 1;
   logic [3:0] rs = 0, ge = 0, gd = 0, pin, prx, srx, g1, g2;
   sap_pkg::sap_pad_s pad;
   sap_pkg::sap_owner_e own;
   int fails = 0, checks_done = 0, cyc = 0;
   sap_pin_share dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_primary_en(pe),
      .i_primary_gpio(pg), .i_primary_rx_sel(rs), .i_primary(8'h9F), .i_second_en(se),
      .i_second_gpio(sg), .i_second(8'h63), .i_gpio_en(ge), .i_gpio_dir(gd),
      .i_gpio_out(4'hF), .i_pin_in(pin), .o_pad(pad), .o_primary_rx(prx),
      .o_second_rx(srx), .o_first_gpio_in(g1), .o_second_gpio_in(g2), .o_owner(own));
   sap_codec_model codec (.i_pad(pad), .i_drive(4'h6), .o_pin(pin));
   always #5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc++;
      if (cyc > 400) begin
         fails++;
         test_done();
      end
   end
   task automatic cmp(input string n, input logic [3:0] e, input logic [3:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic mode(input logic [3:0] m, input logic [3:0] r, input logic [3:0] d);
      @(posedge i_clk);
      #1 {pe, pg, se, sg} = m;
      rs = r;
      ge = 4'hF;
      gd = d;
      repeat (6) @(posedge i_clk);
      #1;
   endtask
   task automatic test_done();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge i_clk);
      #1 i_reset = 0;
      cmp("owner", 4'h1, {1'b0, own});
      cmp("oe", 4'h0, pad.oe);
      mode(4'h0, 4'h0, 4'h5);
      cmp("oe", 4'h5, pad.oe);
      cmp("gpio1", 4'h2, g1);
      mode(4'h3, 4'h0, 4'h0);
      cmp("gpio2", 4'h6, g2);
      cmp("gpio1", 4'h0, g1);
      mode(4'h8, 4'h0, 4'h0);
      cmp("out", 4'h9, pad.out);
      cmp("oe", 4'hF, pad.oe);
      mode(4'h8, 4'hC, 4'h0);
      cmp("prx", 4'h4, prx);
      cmp("oe", 4'h3, pad.oe);
      mode(4'hA, 4'hC, 4'h0);
      cmp("owner", 4'h4, {1'b0, own});
      cmp("out", 4'h2, pad.out & pad.oe);
      cmp("srx", 4'h4, srx & 4'hC);
      ce = 0;
      mode(4'h8, 4'h0, 4'h0);
      cmp("owner", 4'h4, {1'b0, own});
      cmp("out", 4'h2, pad.out & pad.oe);
      ce = 1;
      repeat (3) @(posedge i_clk);
      #1 cmp("owner", 4'h2, {1'b0, own});
      i_reset = 1;
      #1 cmp("owner", 4'h1, {1'b0, own});
      cmp("oe", 4'h0, pad.oe);
      cmp("prx", 4'h0, prx);
      @(posedge i_clk);
      #1 i_reset = 0;
      mode(4'h8, 4'h0, 4'h0);
      cmp("oe", 4'hF, pad.oe);
      test_done();
   end
endmodule
